// ===== src/ssst_chan.sv
// slave three-wire serial channel with wake receive, axi4-lite registers
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
module ssst_chan #(
  parameter int CHAN_ID = 0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_stop,
  input wire logic serial_clock_pin,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic transfer_irq,
  output logic cpu_wake,
  output logic wake_receive_mode
);
  logic [15:0] mode_q, fmt_q, data_q;
  logic olvl_q, op_q, wake_q, unit_en_q, srst;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q, w_have_q, do_wr, rd_take, rd_data_hit;
  logic sck_s1, sck_s2, sck_s3, sdi_s1, sdi_s2;
  ssst_pkg::ssst_st_e st_q;
  logic [3:0] cnt_q, len;
  logic [7:0] tsh_q, rsh_q, src, shifted, rx_next;
  logic bff_q, ovf_q, txf_q;
  logic active, rise, fall, lead, trail, samp, pres, last, load, cur_bit;
  ssst_pkg::ssst_fmt_s f;

  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    wmerge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction : wmerge

  assign srst = rst | ~unit_en_q;

  // write channel: address and data taken in either order
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ssst_pkg::RESP_OK;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (!aw_have_q && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      else if (!w_have_q && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (do_wr)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q[1:0] != 2'b00 || awaddr_q > ssst_pkg::OFS_PER) ?
                       ssst_pkg::RESP_SLVERR : ssst_pkg::RESP_OK;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign rd_data_hit = rd_take & (s_axi_araddr == ssst_pkg::OFS_DATA);

  // read channel: one-cycle answer, reads have no effect on shifting [R4]
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ssst_pkg::RESP_OK;
    end
    else if (rd_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ssst_pkg::RESP_OK;
      case (s_axi_araddr)
        ssst_pkg::OFS_MODE: s_axi_rdata <= {16'h0000, mode_q};
        ssst_pkg::OFS_FMT: s_axi_rdata <= {16'h0000, fmt_q};
        ssst_pkg::OFS_DATA: s_axi_rdata <= {16'h0000, data_q[15:9], 1'b0, data_q[7:0]};
        ssst_pkg::OFS_OLVL: s_axi_rdata <= {31'h0, olvl_q};
        ssst_pkg::OFS_OEN: s_axi_rdata <= {31'h0, serial_data_oe};
        ssst_pkg::OFS_START, ssst_pkg::OFS_STOP: s_axi_rdata <= {31'h0, op_q};
        ssst_pkg::OFS_STAT: s_axi_rdata <= {27'h0, txf_q, op_q, ovf_q, bff_q, st_q};
        ssst_pkg::OFS_STBY: s_axi_rdata <= {31'h0, wake_q};
        ssst_pkg::OFS_FCLR: s_axi_rdata <= 32'h0000_0000;
        ssst_pkg::OFS_PER: s_axi_rdata <= {31'h0, unit_en_q};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= ssst_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // unit enable survives its own unit reset
  always_ff @(posedge core_clk)
  begin
    if (rst)
      unit_en_q <= 1'b0;
    else if (do_wr && awaddr_q == ssst_pkg::OFS_PER && wstrb_q[0])
      unit_en_q <= wdata_q[0];
  end

  // configuration and trigger registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      mode_q <= ssst_pkg::MODE_RST;
      fmt_q <= ssst_pkg::FMT_RST;
      olvl_q <= ssst_pkg::OLVL_RST;
      serial_data_oe <= 1'b0;
      op_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else if (do_wr)
    begin
      case (awaddr_q)
        ssst_pkg::OFS_MODE: mode_q <= wmerge(mode_q, wdata_q, wstrb_q);
        ssst_pkg::OFS_FMT: fmt_q <= wmerge(fmt_q, wdata_q, wstrb_q);
        ssst_pkg::OFS_OLVL: if (wstrb_q[0]) olvl_q <= wdata_q[0]; // [R7]
        ssst_pkg::OFS_OEN: if (wstrb_q[0]) serial_data_oe <= wdata_q[0]; // [R7]
        ssst_pkg::OFS_START: if (wstrb_q[0] && wdata_q[0]) op_q <= 1'b1; // [R8]
        ssst_pkg::OFS_STOP: if (wstrb_q[0] && wdata_q[0]) op_q <= 1'b0;
        // only channel 0 can hold the wake enable
        ssst_pkg::OFS_STBY: if (wstrb_q[0]) wake_q <= wdata_q[0] && CHAN_ID == 0; // [R11]
        default: op_q <= op_q;
      endcase
    end
  end

  // two-stage synchronisers; edges only from settled samples [R25] [R23]
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      // idle level of the clock pin, so no false edge follows reset
      sck_s1 <= 1'b1;
      sck_s2 <= 1'b1;
      sck_s3 <= 1'b1;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end
    else
    begin
      sck_s1 <= serial_clock_pin;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      sdi_s1 <= serial_data_in;
      sdi_s2 <= sdi_s1;
    end
  end

  assign f = '{dap: fmt_q[ssst_pkg::FMT_DAP], ckp: fmt_q[ssst_pkg::FMT_CKP],
               lsb: fmt_q[ssst_pkg::FMT_DIR], len8: fmt_q[ssst_pkg::FMT_DLS]};
  assign rise = sck_s2 & ~sck_s3;
  assign fall = ~sck_s2 & sck_s3;
  assign lead = f.ckp ? rise : fall;
  assign trail = f.ckp ? fall : rise;
  // stop mode freezes the channel unless wake receive is armed [R10]
  assign active = op_q & mode_q[ssst_pkg::MODE_CCS] & (~core_stop | wake_q);
  assign samp = active & (f.dap ? lead : trail); // [R24]
  assign pres = active & (f.dap ? trail : lead); // [R24]
  assign len = f.len8 ? ssst_pkg::LEN8 : ssst_pkg::LEN7;
  assign last = samp & (cnt_q == len - 4'h1);
  // a frame opens only on a leading edge; with data phase 1 the trailing
  // edge after the last bit must not restart the shifter
  assign load = (st_q == ssst_pkg::ST_IDLE) & active & lead;
  // idle shifter reads the data register, so first bit needs no edge [R1]
  assign src = (st_q == ssst_pkg::ST_SHIFT) ? tsh_q : data_q[7:0];
  assign cur_bit = f.lsb ? src[0] : (f.len8 ? src[7] : src[6]);
  assign shifted = f.lsb ? {1'b0, src[7:1]} : {src[6:0], 1'b0};
  assign rx_next = f.lsb ? (f.len8 ? {sdi_s2, rsh_q[7:1]} : {1'b0, sdi_s2, rsh_q[6:1]})
                         : {rsh_q[6:0], sdi_s2};

  // shift engine; state is busy from first active edge to last bit [R27]
  always_ff @(posedge core_clk)
  begin
    if (srst || !op_q)
    begin
      st_q <= ssst_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      tsh_q <= 8'h00;
      rsh_q <= 8'h00;
    end
    else if (samp)
    begin
      tsh_q <= shifted;
      rsh_q <= rx_next;
      st_q <= last ? ssst_pkg::ST_IDLE : ssst_pkg::ST_SHIFT;
      cnt_q <= last ? 4'h0 : cnt_q + 4'h1;
    end
    else if (load)
    begin
      tsh_q <= data_q[7:0];
      st_q <= ssst_pkg::ST_SHIFT;
    end
  end

  // data out: idle level when disabled, or between frames with data phase 0; data phase 1 presents the first bit [R7]
  always_ff @(posedge core_clk)
  begin
    if (srst)
      serial_data_out <= ssst_pkg::OLVL_RST;
    else if (!serial_data_oe)
      serial_data_out <= olvl_q;
    else if (pres)
      serial_data_out <= cur_bit;
    else if (st_q == ssst_pkg::ST_IDLE)
      serial_data_out <= f.dap ? cur_bit : olvl_q; // [R24]
  end

  // shared data register: software write overwrites held data [R3]
  always_ff @(posedge core_clk)
  begin
    if (srst)
      data_q <= ssst_pkg::DATA_RST;
    else
    begin
      if (do_wr && awaddr_q == ssst_pkg::OFS_DATA)
        data_q <= wmerge(data_q, wdata_q, wstrb_q) & 16'hfeff; // [R3]
      // received byte wins the low byte over a same-cycle write
      if (last)
        data_q[7:0] <= f.len8 ? rx_next : {1'b0, rx_next[6:0]};
    end
  end

  // flags: a hardware set beats a same-cycle clear
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      bff_q <= 1'b0;
      ovf_q <= 1'b0;
      txf_q <= 1'b0;
    end
    else
    begin
      if (last && !wake_q)
        bff_q <= 1'b1; // [R20]
      else if (rd_data_hit)
        bff_q <= 1'b0;
      if (last && !wake_q && bff_q)
        ovf_q <= 1'b1; // [R22] [R20]
      else if (do_wr && awaddr_q == ssst_pkg::OFS_FCLR && wstrb_q[0] &&
               wdata_q[ssst_pkg::STAT_OVF])
        ovf_q <= 1'b0;
      if (do_wr && awaddr_q == ssst_pkg::OFS_DATA && wstrb_q[0])
        txf_q <= 1'b1; // [R3]
      else if (load)
        txf_q <= 1'b0;
    end
  end

  // interrupt pulse: frame end or buffer empty per source select; frame end regardless of source select while the wake bit is set [R21]
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      transfer_irq <= 1'b0;
      cpu_wake <= 1'b0;
      wake_receive_mode <= 1'b0;
    end
    else
    begin
      transfer_irq <= (last && (!mode_q[ssst_pkg::MODE_IRQSEL] || wake_q)) ||
                      (load && mode_q[ssst_pkg::MODE_IRQSEL] && !wake_q); // [R26]
      cpu_wake <= last && wake_q && core_stop; // [R26]
      if (!core_stop)
        wake_receive_mode <= 1'b0;
      else if (wake_q && active && (rise || fall))
        wake_receive_mode <= 1'b1; // [R14]
    end
  end
endmodule : ssst_chan

// ===== common/ssst_pkg.sv
// shared constants and types for the slave sync serial channel
// Function
// R1: software loads first transmit byte before master starts the serial clock.
// R2: software keeps divider bits 15..9 of data register zero in slave use.
// R3: writing data while buffer full replaces held transmit data.
// R4: reading pending transmit data never disturbs the shift operation.
// R5: software changes interrupt source select before last bit begins.
// R6: software initialises unit enable, clock, mode, format, data, level in order.
// R7: output level register sets idle data level; enable bit enables data output.
// R8: writing 1 to start trigger sets the operating status bit.
// R9: after unit enable rewrite in stop, software fully reinitialises.
// R10: in stop mode channel halts unless wake receive is enabled.
// R11: wake receive enable is accepted by channel 0 only.
// R12: software sets wake bit just before entering stop mode.
// R13: software starts channel 0 before entering stop mode.
// R14: in stop, valid clock edge enters wake state and starts reception.
// R15: wake receive only with fast on-chip oscillator as system clock.
// R16: master keeps link at or below 1 Mbps during wake receive.
// R17: software reads wake data while wake bit set, before next edge.
// R18: software stops channel 0 before and after wake receive.
// R19: software clears wake bit after wake reception completes.
// R20: while wake bit set, receive full and overrun flags hold.
// R21: source select picks transfer end or buffer empty interrupt.
// R22: only error is overrun, set when unread data gets overwritten.
// R23: serial clock sampled by core clock, limiting rate to one sixth.
// R24: data phase 1 starts data input and output half a period earlier.
// R25: serial clock passes two-stage synchroniser; edges drive shift and sample.
// R26: in wake receive, each finished frame raises interrupt and wakes core.
// R27: transfer status high from first active edge until last bit shifted.
package ssst_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_FMT = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_OLVL = 8'h0c;
  localparam logic [7:0] OFS_OEN = 8'h10;
  localparam logic [7:0] OFS_START = 8'h14;
  localparam logic [7:0] OFS_STOP = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;
  localparam logic [7:0] OFS_STBY = 8'h20;
  localparam logic [7:0] OFS_FCLR = 8'h24;
  localparam logic [7:0] OFS_PER = 8'h28;
  localparam int MODE_IRQSEL = 0;
  localparam int MODE_CCS = 14;
  localparam int FMT_DAP = 13;
  localparam int FMT_CKP = 12;
  localparam int FMT_DIR = 7;
  localparam int FMT_DLS = 0;
  localparam int STAT_TSF = 0;
  localparam int STAT_BFF = 1;
  localparam int STAT_OVF = 2;
  localparam int STAT_OP = 3;
  localparam int STAT_TXF = 4;
  localparam logic [15:0] MODE_RST = 16'h0020;
  localparam logic [15:0] FMT_RST = 16'h0007;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic OLVL_RST = 1'b1;
  localparam logic [3:0] LEN8 = 4'h8;
  localparam logic [3:0] LEN7 = 4'h7;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef struct packed {
    logic dap;
    logic ckp;
    logic lsb;
    logic len8;
  } ssst_fmt_s;
  typedef enum logic {ST_IDLE = 1'b0, ST_SHIFT = 1'b1} ssst_st_e;
endpackage : ssst_pkg

// ===== testbench/ssst_monitor.sv
// port assertions for the slave sync serial channel
module ssst_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic core_stop,
  input wire logic serial_clock_pin,
  input wire logic serial_data_out,
  input wire logic transfer_irq,
  input wire logic cpu_wake,
  input wire logic wake_receive_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_irq_pulse; transfer_irq |=> !transfer_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than a cycle");
  property p_wake_src; cpu_wake |-> $past(core_stop) && wake_receive_mode; endproperty
  a_wake_src: assert property (p_wake_src) else $error("wake outside stop");
  property p_wake_irq; cpu_wake |-> transfer_irq; endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake without irq");
  property p_wake_exit; !core_stop |=> !wake_receive_mode; endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("wake mode kept");
  property p_wake_entry; $rose(wake_receive_mode) |-> $past(core_stop); endproperty
  a_wake_entry: assert property (p_wake_entry) else $error("wake mode in run");
  property p_stop_quiet; core_stop && !wake_receive_mode |-> !cpu_wake; endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("stopped channel woke");
  // sdo may only follow a synchronised edge, never the raw pin
  property p_sync_lag; $changed(serial_clock_pin) |=> $stable(serial_data_out) [*2]; endproperty
  a_sync_lag: assert property (p_sync_lag) else $error("sdo moved too early");
  property p_ar_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read not answered");
endmodule : ssst_monitor
bind ssst_chan ssst_monitor i_ssst_monitor (
  .core_clk, .rst, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .core_stop,
  .serial_clock_pin, .serial_data_out, .transfer_irq, .cpu_wake, .wake_receive_mode
);

// ===== testbench/ssst_master_model.sv
// behavioural serial master that makes the link clock and data
module ssst_master_model (
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sclk = 1'b1;
    sdi = 1'b0;
  end
  // msb first on the wire; clock idles high and stands still between frames
  task automatic xfer(input logic [7:0] tx, input logic dap, input realtime half,
    output logic [7:0] rx);
    #3; // keeps every link edge off the core clock edges
    for (int i = 7; i >= 0; i--)
    begin
      sclk = dap;
      sdi = tx[i];
      #(half);
      rx[i] = sdo;
      sclk = !dap;
      #(half);
      sclk = 1'b1;
    end
    sdi = !sdi; // released line never repeats the last bit
  endtask : xfer
endmodule : ssst_master_model

// ===== testbench/tb.sv
// self-checking bench: register bus, serial frames, wake receive
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 20000;
  logic core_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, core_stop;
  logic arvalid, arready, rvalid, rready, sclk, sdi, sdo, oe, irq, wake, wmode;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int miscompares, num_checks, cyc, irqs, wakes;
  ssst_chan i_ssst_chan (
    .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_stop(core_stop), .serial_clock_pin(sclk), .serial_data_in(sdi),
    .serial_data_out(sdo), .serial_data_oe(oe), .transfer_irq(irq), .cpu_wake(wake),
    .wake_receive_mode(wmode)
  );
  ssst_master_model i_ssst_master_model (.sclk(sclk), .sdi(sdi), .sdo(sdo));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk; // stands for the fast on-chip oscillator
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    irqs <= irqs + int'(irq === 1'b1);
    wakes <= wakes + int'(wake === 1'b1);
    if (cyc == LIMIT)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  function automatic logic [7:0] order(input logic [7:0] v, input logic lsb);
    for (int i = 0; i < 8; i++)
      order[i] = lsb ? v[7-i] : v[i];
  endfunction : order
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge core_clk);
    {awaddr, wdata} <= {a, 16'h0000, v};
    {awvalid, wvalid, bready} <= 3'h7;
    while (!(aw && w))
    begin
      @(posedge core_clk);
      awvalid <= !(aw || awready);
      wvalid <= !(w || wready);
      aw = aw || awready;
      w = w || wready;
    end
    while (!bvalid) @(posedge core_clk);
    bready <= 1'b0;
    chk("bresp", 32'h0, {30'h0, bresp});
  endtask : wr
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] m, e,
    input logic [1:0] r = 2'b00);
    @(posedge core_clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do @(posedge core_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (!rvalid);
    rready <= 1'b0;
    chk(n, e, rdata & m);
    chk("rresp", {30'h0, r}, {30'h0, rresp});
  endtask : rc
  initial
  begin
    logic [7:0] tx, rx, got;
    logic [2:0] fm;
    logic [31:0] d;
    {rst, core_stop, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
    {awaddr, araddr, wdata} = '0;
    d = $urandom(26712);
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rc("mode", ssst_pkg::OFS_MODE, 32'hffff, {16'h0, ssst_pkg::MODE_RST});
    rc("format", ssst_pkg::OFS_FMT, 32'hffff, {16'h0, ssst_pkg::FMT_RST});
    rc("unmapped", 8'h40, 32'hffffffff, 32'h0, ssst_pkg::RESP_SLVERR);
    chk("idle sdo", 32'h1, {31'h0, sdo});
    $display("test reset done");
    wr(ssst_pkg::OFS_PER, 16'h0001);
    wr(ssst_pkg::OFS_MODE, 16'h4020);
    wr(ssst_pkg::OFS_DATA, 16'h0000);
    wr(ssst_pkg::OFS_OLVL, 16'h0001);
    wr(ssst_pkg::OFS_OEN, 16'h0001);
    chk("oe", 32'h1, {31'h0, oe});
    wr(ssst_pkg::OFS_START, 16'h0001);
    rc("operating", ssst_pkg::OFS_STAT, 32'h8, 32'h8);
    for (int i = 0; i < 8; i++)
    begin
      fm = 3'(i);
      tx = (i == 7) ? 8'h00 : 8'($urandom);
      rx = (i == 7) ? 8'hff : 8'($urandom);
      wr(ssst_pkg::OFS_MODE, {15'h2010, fm[2]});
      wr(ssst_pkg::OFS_FMT, {2'b00, fm[1], 5'h00, fm[0], 7'h07});
      wr(ssst_pkg::OFS_DATA, {8'h00, ~tx});
      wr(ssst_pkg::OFS_DATA, {8'h00, tx});
      rc("pending tx", ssst_pkg::OFS_DATA, 32'hff, {24'h0, tx});
      d = irqs;
      i_ssst_master_model.xfer(rx, fm[1], 62.5, got);
      repeat (12) @(posedge core_clk);
      chk("sent byte", {24'h0, order(tx, fm[0])}, {24'h0, got});
      chk("irq count", d + 1, irqs);
      rc("rx full", ssst_pkg::OFS_STAT, 32'h13, 32'h2);
      rc("rx byte", ssst_pkg::OFS_DATA, 32'hff, {24'h0, order(rx, fm[0])});
    end
    $display("test frames done");
    repeat (2) i_ssst_master_model.xfer(8'($urandom), fm[1], 62.5, got);
    repeat (12) @(posedge core_clk);
    rc("overrun", ssst_pkg::OFS_STAT, 32'h4, 32'h4);
    wr(ssst_pkg::OFS_FCLR, 16'h0004);
    rc("overrun clear", ssst_pkg::OFS_STAT, 32'h4, 32'h0);
    rc("drain", ssst_pkg::OFS_DATA, 32'hffffff00, 32'h0);
    $display("test overrun done");
    @(posedge core_clk);
    core_stop <= 1'b1;
    d = irqs;
    i_ssst_master_model.xfer(8'h5a, fm[1], 62.5, got);
    repeat (12) @(posedge core_clk);
    chk("stopped irq", d, irqs);
    core_stop <= 1'b0;
    rx = 8'($urandom);
    wr(ssst_pkg::OFS_STOP, 16'h0001);
    wr(ssst_pkg::OFS_DATA, 16'h0000);
    wr(ssst_pkg::OFS_START, 16'h0001);
    wr(ssst_pkg::OFS_STBY, 16'h0001);
    @(posedge core_clk);
    core_stop <= 1'b1;
    d = wakes;
    i_ssst_master_model.xfer(rx, fm[1], 500.0, got);
    repeat (12) @(posedge core_clk);
    chk("wake mode", 32'h1, {31'h0, wmode});
    chk("wake count", d + 1, wakes);
    rc("flags held", ssst_pkg::OFS_STAT, 32'h6, 32'h0);
    rc("wake byte", ssst_pkg::OFS_DATA, 32'hff, {24'h0, order(rx, fm[0])});
    core_stop <= 1'b0;
    wr(ssst_pkg::OFS_STOP, 16'h0001);
    wr(ssst_pkg::OFS_STBY, 16'h0000);
    chk("wake left", 32'h0, {31'h0, wmode});
    $display("test wake done");
    wr(ssst_pkg::OFS_PER, 16'h0000);
    wr(ssst_pkg::OFS_PER, 16'h0001);
    rc("unit reset", ssst_pkg::OFS_MODE, 32'hffff, {16'h0, ssst_pkg::MODE_RST});
    $display("test unit reset done");
    summarize();
  end
endmodule : tb
